// *** rtl/load_diag_config_and_report_regs.v ***
// Register bank for load diagnostic thresholds, results and channel state report.
`timescale 1ns/10ps
`default_nettype none
`include "load_diag_regs.vh"

module load_diag_config_and_report_regs #(
  parameter CHANNELS = 4
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  output reg         reg_rvalid,
  input  wire [3:0]  diag_done,
  input  wire [15:0] diag_flags,
  input  wire [3:0]  line_detected,
  input  wire [7:0]  actual_state,
  input  wire [3:0]  channel_fault,
  output wire [15:0] short_threshold,
  output reg  [7:0]  requested_state,
  output wire [3:0]  auto_diag_start,
  output reg         auto_diag_suppress,
  output reg         line_level_detect_on
);

  // Writable configuration registers.
  reg  [7:0]  ch12_short_threshold_reg;
  reg  [7:0]  ch34_short_threshold_reg;

  // Per-channel results gathered from the trackers, channel one in the top lanes.
  wire [15:0] result_flags;
  wire [3:0]  line_flags;
  wire [7:0]  state_report;
  wire [15:0] threshold_codes;
  reg  [7:0]  rdata_next;

  assign threshold_codes = {ch12_short_threshold_reg, ch34_short_threshold_reg};

  // Host writes; read-only offsets fall through so writes to them change nothing.
  always @(posedge mclk) begin
    if (rst) begin
      requested_state          <= `RST_STATE_CONTROL;
      auto_diag_suppress       <= 1'b0;
      line_level_detect_on     <= 1'b0;
      ch12_short_threshold_reg <= `RST_THRESHOLD;
      ch34_short_threshold_reg <= `RST_THRESHOLD;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFS_STATE_CONTROL: begin
          requested_state <= reg_wdata;
        end
        `OFS_DIAG_CONTROL: begin
          auto_diag_suppress   <= reg_wdata[`BIT_DIAG_SUPPRESS];
          line_level_detect_on <= reg_wdata[`BIT_LINE_DETECT_ON];
        end
        `OFS_CH12_THRESHOLD: begin
          ch12_short_threshold_reg <= reg_wdata;
        end
        `OFS_CH34_THRESHOLD: begin
          ch34_short_threshold_reg <= reg_wdata;
        end
        default: begin
          ch34_short_threshold_reg <= ch34_short_threshold_reg;
        end
      endcase
    end
  end

  // Read mux; unmapped offsets and reserved bits read as zero.
  always @* begin
    rdata_next = 8'h00;
    case (reg_addr)
      `OFS_STATE_CONTROL:  rdata_next = requested_state;
      `OFS_DIAG_CONTROL:   rdata_next = {6'h00, line_level_detect_on, auto_diag_suppress};
      `OFS_CH12_THRESHOLD: rdata_next = ch12_short_threshold_reg;
      `OFS_CH34_THRESHOLD: rdata_next = ch34_short_threshold_reg;
      `OFS_CH12_RESULT:    rdata_next = result_flags[15:8];
      `OFS_CH34_RESULT:    rdata_next = result_flags[7:0];
      `OFS_LINE_RESULT:    rdata_next = {4'h0, line_flags};
      `OFS_ACTUAL_STATE:   rdata_next = state_report;
      default:             rdata_next = 8'h00;
    endcase
  end

  // Read data is registered so it stays stable for the bus while the trackers move on.
  always @(posedge mclk) begin
    if (rst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

  // One tracker per channel; channel one sits in the most significant field of each group.
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
      diag_channel_track u_track (
        .mclk                 (mclk),
        .rst                  (rst),
        .threshold_code       (threshold_codes[15-4*ch -: 4]),
        .auto_diag_suppress   (auto_diag_suppress),
        .line_level_detect_on (line_level_detect_on),
        .diag_done            (diag_done[3-ch]),
        .diag_flags           (diag_flags[15-4*ch -: 4]),
        .line_detected        (line_detected[3-ch]),
        .actual_state         (actual_state[7-2*ch -: 2]),
        .channel_fault        (channel_fault[3-ch]),
        .result_flags_reg     (result_flags[15-4*ch -: 4]),
        .line_flag_reg        (line_flags[3-ch]),
        .state_reg            (state_report[7-2*ch -: 2]),
        .threshold_reg        (short_threshold[15-4*ch -: 4]),
        .auto_start_reg       (auto_diag_start[3-ch])
      );
    end
  endgenerate

endmodule // load_diag_config_and_report_regs
`default_nettype wire

// *** rtl/load_diag_regs.vh ***
// Register offsets, field codes, reset values and function list for the load diagnostic bank.
// Function
// - Each channel's shorted-load threshold is a 4-bit code from 0000 (0.5 ohm) in 0.5 ohm steps to 1001 (5 ohm), and a load below it is flagged as shorted.
// - The threshold register for channels three and four is at offset 0x0B, with channel three in bits 7..4 and channel four in bits 3..0, both read/write.
// - Every threshold code resets to 0001, so each threshold register reads 0x11 until software rewrites it.
// - The first result register, at offset 0x0C, holds channel one's flags in bits 7..4 and channel two's in bits 3..0, ordered short-to-ground, short-to-supply, open load, shorted load.
// - The second result register, at offset 0x0D, holds the same flags in the same order for channel three in bits 7..4 and channel four in bits 3..0.
// - Result flags are read-only, reset to zero, read 1 only when the condition was detected, and ignore host writes.
// - The line-level result register, at offset 0x0E, reports channels one to four in bits 3 down to 0, and bits 7..4 read zero.
// - The read-only state report at offset 0x0F gives channel one bits 7..6 through channel four bits 1..0 and resets to 0x55.
// - A state field reads 00 playing, 01 floating output, 10 muted and 11 running load diagnostics.
// - Unless the suppress bit is set, a diagnostic run starts automatically when a channel leaves the floating state and after a channel fault.
// - Line-level detection counts only while the line-level enable bit is 1, otherwise its flags never rise.
`ifndef LOAD_DIAG_REGS_VH
`define LOAD_DIAG_REGS_VH

`define OFS_STATE_CONTROL   8'h04
`define OFS_DIAG_CONTROL    8'h09
`define OFS_CH12_THRESHOLD  8'h0a
`define OFS_CH34_THRESHOLD  8'h0b
`define OFS_CH12_RESULT     8'h0c
`define OFS_CH34_RESULT     8'h0d
`define OFS_LINE_RESULT     8'h0e
`define OFS_ACTUAL_STATE    8'h0f

`define RST_STATE_CONTROL   8'h55
`define RST_DIAG_CONTROL    8'h00
`define RST_THRESHOLD       8'h11
`define RST_RESULT          8'h00
`define RST_ACTUAL_STATE    8'h55

`define BIT_DIAG_SUPPRESS   0
`define BIT_LINE_DETECT_ON  1

`define THRESHOLD_MAX_CODE  4'h9
`define THRESHOLD_RST_CODE  4'h1

`define STATE_PLAY          2'h0
`define STATE_FLOATING      2'h1
`define STATE_MUTE          2'h2
`define STATE_DIAG          2'h3

`endif

// *** rtl/diag_channel_track.v ***
// One channel's result flags, state report, threshold clamp and automatic diagnostic trigger.
`timescale 1ns/10ps
`default_nettype none
`include "load_diag_regs.vh"

module diag_channel_track (
  input  wire       mclk,
  input  wire       rst,
  input  wire [3:0] threshold_code,
  input  wire       auto_diag_suppress,
  input  wire       line_level_detect_on,
  input  wire       diag_done,
  input  wire [3:0] diag_flags,
  input  wire       line_detected,
  input  wire [1:0] actual_state,
  input  wire       channel_fault,
  output reg  [3:0] result_flags_reg,
  output reg        line_flag_reg,
  output reg  [1:0] state_reg,
  output reg  [3:0] threshold_reg,
  output reg        auto_start_reg
);

  // Leaving the floating state is seen against the previous reported state.
  wire leaving_float = (state_reg == `STATE_FLOATING) && (actual_state != `STATE_FLOATING);

  // Flags are only replaced at the end of a run, so a read in mid-run still shows the last result.
  always @(posedge mclk) begin
    if (rst) begin
      result_flags_reg <= 4'h0;
      line_flag_reg    <= 1'b0;
      state_reg        <= `STATE_FLOATING;
      threshold_reg    <= `THRESHOLD_RST_CODE;
      auto_start_reg   <= 1'b0;
    end else begin
      if (diag_done) begin
        result_flags_reg <= diag_flags;
        line_flag_reg    <= line_detected & line_level_detect_on;
      end
      state_reg <= actual_state;
      // Undefined codes are clamped rather than extrapolated past the top step.
      if (threshold_code > `THRESHOLD_MAX_CODE) begin
        threshold_reg <= `THRESHOLD_MAX_CODE;
      end else begin
        threshold_reg <= threshold_code;
      end
      auto_start_reg <= ~auto_diag_suppress & (leaving_float | channel_fault);
    end
  end

endmodule // diag_channel_track
`default_nettype wire

// *** verification/load_diag_chk.sv ***
// Assertion checker for the load diagnostic register bank.
`timescale 1ns/10ps
`default_nettype none
module load_diag_chk (
  input wire logic        mclk, rst, reg_wr, reg_rd, auto_diag_suppress,
  input wire logic [7:0]  reg_addr, reg_wdata, reg_rdata, actual_state,
  input wire logic [3:0]  diag_done, channel_fault, auto_diag_start,
  input wire logic [15:0] diag_flags, short_threshold
);
  // One clock domain, so reset masks every check unless a property says otherwise.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_rst; disable iff (1'b0) rst [*2] |-> short_threshold == 16'h1111; endproperty
  a_rst: assert property (p_rst) else $error("bad reset code");
  property p_clamp; short_threshold[15:12] <= 4'h9 && short_threshold[7:4] <= 4'h9; endproperty
  a_clamp: assert property (p_clamp) else $error("code not clamped");
  property p_wr; reg_wr && reg_addr == 8'h0b && reg_wdata[3:0] <= 4'h9 |-> ##2
    short_threshold[3:0] == $past(reg_wdata[3:0], 2); endproperty
  a_wr: assert property (p_wr) else $error("code not applied");
  property p_st; reg_rd && reg_addr == 8'h0f |=> reg_rdata == $past(actual_state, 2); endproperty
  a_st: assert property (p_st) else $error("bad state report");
  property p_lo; reg_rd && reg_addr == 8'h0e |=> reg_rdata[7:4] == 4'h0; endproperty
  a_lo: assert property (p_lo) else $error("reserved bits set");
  property p_res; diag_done[3] ##1 (reg_rd && reg_addr == 8'h0c) |=>
    reg_rdata[7:4] == $past(diag_flags[15:12], 2); endproperty
  a_res: assert property (p_res) else $error("bad result flags");
  property p_auto; !auto_diag_suppress |=>
    (auto_diag_start & $past(channel_fault)) == $past(channel_fault); endproperty
  a_auto: assert property (p_auto) else $error("no automatic start");
  property p_sup; auto_diag_suppress [*2] |-> auto_diag_start == 4'h0; endproperty
  a_sup: assert property (p_sup) else $error("start not suppressed");
  c_done: cover property (diag_done != 4'h0);
  c_auto: cover property (auto_diag_start != 4'h0);
  c_sup: cover property (auto_diag_suppress && channel_fault != 4'h0);
endmodule // load_diag_chk
bind load_diag_config_and_report_regs load_diag_chk u_chk (.mclk, .rst, .reg_wr, .reg_rd,
  .auto_diag_suppress, .reg_addr, .reg_wdata, .reg_rdata, .actual_state, .diag_done,
  .channel_fault, .auto_diag_start, .diag_flags, .short_threshold);
`default_nettype wire

// *** verification/diag_seq_model.sv ***
// Behavioural diagnostic sequencer and channel state machine facing the bank.
`timescale 1ns/10ps
`default_nettype none
module diag_seq_model #(parameter int DLY = 3) (
  input wire logic        mclk, rst,
  input wire logic [3:0]  go, line_in,
  input wire logic [15:0] flags_in,
  output logic     [3:0]  done, line,
  output logic     [15:0] flags,
  output logic     [7:0]  state
);
  logic [3:0] busy, cnt;
  // Result lines carry junk outside the done cycle, so late sampling shows up.
  assign flags = done != 4'h0 ? flags_in : ~flags_in;
  assign line = done != 4'h0 ? line_in : ~line_in;
  // One run at a time; a request while busy is dropped.
  always @(posedge mclk) begin
    done <= 4'h0;
    cnt <= cnt + 4'h1;
    if (rst) begin
      busy <= 4'h0;
      cnt <= 4'h0;
      state <= 8'h55;
    end else if (busy == 4'h0 && go != 4'h0) begin
      busy <= go;
      cnt <= 4'h0;
      for (int i = 0; i < 4; i++) if (go[i]) state[2*i+:2] <= 2'h3;
    end else if (busy != 4'h0 && cnt == 4'(DLY)) begin
      done <= busy;
      busy <= 4'h0;
      for (int i = 0; i < 4; i++) if (busy[i]) state[2*i+:2] <= 2'h0;
    end
  end
endmodule // diag_seq_model
`default_nettype wire

// *** verification/tb_load_diag_config_and_report_regs.sv ***
// Self-checking bench for the load diagnostic register bank.
`timescale 1ns/10ps
`default_nettype none
module tb_load_diag_config_and_report_regs;
  logic        mclk, rst, reg_wr, reg_rd, reg_rvalid, sup, lon;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, actual_state, req;
  logic [3:0]  go, run, done, line, fault, start, line_in;
  logic [15:0] flags, fin, thr;
  int          err_count, total_checks, n;
  // Rows are {write, offset, data}; a read row expects its data back.
  logic [16:0] rows [17] = '{17'h00a11, 17'h00b11, 17'h00c00, 17'h00d00, 17'h00e00, 17'h00f55,
    17'h00455, 17'h00900, 17'h02000, 17'h10cff, 17'h00c00, 17'h10f00, 17'h00f55, 17'h10ba7,
    17'h00ba7, 17'h10a90, 17'h00a90};
  assign run = go | start;
  load_diag_config_and_report_regs u_dut (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .reg_rvalid, .diag_done(done), .diag_flags(flags), .line_detected(line),
    .actual_state, .channel_fault(fault), .short_threshold(thr), .requested_state(req),
    .auto_diag_start(start), .auto_diag_suppress(sup), .line_level_detect_on(lon));
  diag_seq_model u_seq (.mclk, .rst, .go(run), .line_in, .flags_in(fin), .done, .line, .flags,
    .state(actual_state));
  task automatic chk(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // The strobe stays up between rows, so accesses run back to back.
  task automatic acc(input logic [16:0] r);
    {reg_wr, reg_addr, reg_wdata} = r;
    reg_rd = !r[16];
    @(posedge mclk) #5;
    if (!r[16]) chk({7'h0, reg_rvalid, reg_rdata}, {8'h01, r[7:0]});
  endtask
  task automatic kick(input logic [3:0] g, f);
    go = g;
    fault = f;
    @(posedge mclk) #5;
    go = 4'h0;
    fault = 4'h0;
  endtask
  task automatic wait_done();
    for (n = 0; n < 20 && done === 4'h0; n++) @(posedge mclk) #5;
    if (n == 20) begin
      chk(16'h0, 16'h1);
      close_out();
    end else begin
      @(posedge mclk) #5;
    end
  endtask
  task automatic close_out();
    if (err_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Reset, the row table, then diagnostic runs, line detection and fault starts.
  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata, go, fault} = {1'b1, 26'h0};
    fin = 16'ha5c3;
    line_in = 4'hf;
    repeat (12) @(posedge mclk);
    #5 rst = 1'b0;
    foreach (rows[i]) acc(rows[i]);
    @(posedge mclk) #5;
    chk(thr, 16'h9097);
    chk({req, 6'h0, lon, sup}, 16'h5500);
    kick(4'h8, 4'h0);
    @(posedge mclk) #5;
    chk({12'h0, start}, 16'h0008);
    acc(17'h00fd5);
    wait_done();
    acc(17'h00ca0);
    acc(17'h00e00);
    acc(17'h00f15);
    acc(17'h10902);
    kick(4'h3, 4'h0);
    wait_done();
    acc(17'h00dc3);
    acc(17'h00e03);
    kick(4'h0, 4'h4);
    chk({12'h0, start}, 16'h0004);
    wait_done();
    acc(17'h00ca5);
    acc(17'h10903);
    chk({14'h0, lon, sup}, 16'h0003);
    kick(4'h0, 4'h4);
    chk({12'h0, start}, 16'h0000);
    close_out();
  end
endmodule // tb_load_diag_config_and_report_regs
`default_nettype wire
